// ### logic/cell_params.svh
// constants for the register access cell bank
`ifndef CELL_PARAMS_SVH
`define CELL_PARAMS_SVH

// ==========================================================
// widths and address space
`define DATA_W 16
`define IDX_W 6
`define REG_COUNT 6'h20

// ==========================================================
// register indices, byte address is four times the index
`define IDX_CTRL 6'h00
`define IDX_STAT 6'h01
`define IDX_WO 6'h02
`define IDX_RWH 6'h03
`define IDX_VIRT 6'h04
`define IDX_LHSC 6'h05
`define IDX_LLSC 6'h06
`define IDX_LHMK 6'h07
`define IDX_LLMK 6'h08
`define IDX_IHSC 6'h09
`define IDX_ILSC 6'h0a
`define IDX_IHMK 6'h0b
`define IDX_ILMK 6'h0c
`define IDX_IEN 6'h0d
`define IDX_LOR 6'h0e
`define IDX_SC 6'h0f

// ==========================================================
// reset values and bus answers
`define WORD_RST 16'h0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### logic/cell_pkg.sv
// types shared by the register access cell bank
`include "cell_params.svh"

package cell_pkg;
  typedef logic [`DATA_W-1:0] word_t;
  typedef enum {EV_LATCH_HIGH, EV_LATCH_LOW, EV_EDGE_RISE, EV_EDGE_FALL} ev_mode_e;
endpackage

// ### logic/event_cell.sv
// latch and interrupt status cells, cleared by read or by written mask
`timescale 1ns/1ps

module event_cell #(
  parameter int W = 16,
  parameter cell_pkg::ev_mode_e MODE = cell_pkg::EV_LATCH_HIGH,
  parameter bit CLR_ON_READ = 1'b1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // hardware side
  input wire logic [W-1:0] sig,
  // software side
  input wire logic rd_clr,
  input wire logic wr_clr,
  input wire logic [W-1:0] wr_mask,
  output logic [W-1:0] q
);
  import cell_pkg::*;

  // ==========================================================
  // set and clear
  logic [W-1:0] prev;
  logic [W-1:0] next_prev;
  logic [W-1:0] next_q;
  logic [W-1:0] set;
  logic [W-1:0] clr;

  always_comb begin
    next_prev = sig;
    unique case (MODE)
      EV_LATCH_HIGH: set = sig;
      EV_LATCH_LOW: set = ~sig;
      EV_EDGE_RISE: set = sig & ~prev;
      EV_EDGE_FALL: set = ~sig & prev;
    endcase
    // mask cells ignore reads, read cells ignore writes
    if (CLR_ON_READ) begin
      clr = {W{rd_clr}};
    end else begin
      clr = wr_clr ? wr_mask : '0;
    end
    // set beats clear so an event in the clearing cycle survives
    next_q = (q & ~clr) | set;
  end

  // prev starts low, so a level already high at reset counts as a rise
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prev <= '0;
      q <= '0;
    end else begin
      prev <= next_prev;
      q <= next_q;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // rst_n in the antecedent keeps the release edge from checking a reset value
  set_wins_a: assert property ((rst_n && set != '0) |=> ((q & $past(set)) == $past(set)))
    else $error("event lost in clearing cycle");
  hold_a: assert property (!(CLR_ON_READ ? rd_clr : wr_clr) |=>
    ((q & $past(q)) == $past(q)))
    else $error("status bit dropped without a clear");
  mask_only_a: assert property ((!CLR_ON_READ && wr_clr && set == '0) |=>
    (q == ($past(q) & ~$past(wr_mask))))
    else $error("mask clear touched wrong bits");
endmodule

// ### logic/reg_cells.sv
// register file with one register per access cell type, on an AXI4-Lite slave
// Operation
// - rw cell readable, writable, drives hardware
// - read cell loaded via flop, writes ignored
// - write cell accepts software writes
// - hardware-affected cell, hardware wins collisions
// - read-only cell set via one-cycle stage
// - virtual cell returns live signal, no storage
// - latch high, read returns then clears
// - latch low level, read clears
// - latch high, writing ones clears bits
// - latch low, cleared by written mask
// - rising edge sets, read clears
// - falling edge sets, read clears
// - rising and falling edge mask cells cleared only by written mask
// - enable cell gates interrupt sources
// - latch input first cycle after reset
// - write makes one-cycle strobe, readable
// - self-clearing cell drives hardware until done
// - words 00h to 1Fh, one word each
`timescale 1ns/1ps
`include "cell_params.svh"

module reg_cells #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // hardware inputs
  input wire cell_pkg::word_t hw_status_in,
  input wire cell_pkg::word_t hw_data,
  input wire logic hw_load,
  input wire cell_pkg::word_t direct_mux_read,
  input wire cell_pkg::word_t lat_src,
  input wire cell_pkg::word_t irq_src,
  input wire cell_pkg::word_t strap_in,
  input wire cell_pkg::word_t hw_done,
  // hardware outputs
  output cell_pkg::word_t ctrl_word,
  output cell_pkg::word_t wo_word,
  output cell_pkg::word_t rwh_word,
  output cell_pkg::word_t lor_word,
  output cell_pkg::word_t sc_word,
  output cell_pkg::word_t sc_strobe,
  output logic event_req
);
  import cell_pkg::*;

  // ==========================================================
  // bus state
  logic aw_full, next_aw_full;
  logic w_full, next_w_full;
  logic [`IDX_W-1:0] aw_idx, next_aw_idx;
  word_t wdata_q, next_wdata_q;
  logic [1:0] wstrb_q, next_wstrb_q;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic do_wr, wr_ok, rd_fire;
  logic [`IDX_W-1:0] ar_idx;
  word_t bmask, rd_word;
  logic rd_err;

  assign ar_idx = araddr[`IDX_W+1:2];
  assign do_wr = aw_full && w_full && !bvalid;
  assign wr_ok = do_wr && (aw_idx < `REG_COUNT);
  assign rd_fire = arvalid && arready;
  assign bmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  always_comb begin
    next_aw_full = aw_full ? !do_wr : (awvalid && awready);
    next_aw_idx = (awvalid && awready) ? awaddr[`IDX_W+1:2] : aw_idx;
    next_w_full = w_full ? !do_wr : (wvalid && wready);
    next_wdata_q = (wvalid && wready) ? wdata[15:0] : wdata_q;
    next_wstrb_q = (wvalid && wready) ? wstrb[1:0] : wstrb_q;
    next_bvalid = do_wr || (bvalid && !bready);
    next_bresp = do_wr ? (wr_ok ? `RESP_OKAY : `RESP_SLVERR) : bresp;
    next_awready = !next_aw_full && !next_bvalid;
    next_wready = !next_w_full && !next_bvalid;
    next_rvalid = rd_fire || (rvalid && !rready);
    next_rdata = rd_fire ? {16'h0000, rd_word} : rdata;
    next_rresp = rd_fire ? (rd_err ? `RESP_SLVERR : `RESP_OKAY) : rresp;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_idx <= '0;
      wdata_q <= `WORD_RST;
      wstrb_q <= 2'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      aw_idx <= next_aw_idx;
      wdata_q <= next_wdata_q;
      wstrb_q <= next_wstrb_q;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // ==========================================================
  // status cells
  word_t lhsc, llsc, lhmk, llmk, ihsc, ilsc, ihmk, ilmk;

  event_cell #(.W(`DATA_W), .MODE(EV_LATCH_HIGH), .CLR_ON_READ(1'b1)) u_lhsc (
    .core_clk(core_clk), .rst_n(rst_n), .sig(lat_src),
    .rd_clr(rd_fire && ar_idx == `IDX_LHSC), .wr_clr(1'b0), .wr_mask(bmask),
    .q(lhsc));
  event_cell #(.W(`DATA_W), .MODE(EV_LATCH_LOW), .CLR_ON_READ(1'b1)) u_llsc (
    .core_clk(core_clk), .rst_n(rst_n), .sig(lat_src),
    .rd_clr(rd_fire && ar_idx == `IDX_LLSC), .wr_clr(1'b0), .wr_mask(bmask),
    .q(llsc));
  event_cell #(.W(`DATA_W), .MODE(EV_LATCH_HIGH), .CLR_ON_READ(1'b0)) u_lhmk (
    .core_clk(core_clk), .rst_n(rst_n), .sig(lat_src),
    .rd_clr(1'b0), .wr_clr(wr_ok && aw_idx == `IDX_LHMK), .wr_mask(wdata_q & bmask),
    .q(lhmk));
  // latch-low mask cell is cleared by mask only, reads leave it alone
  event_cell #(.W(`DATA_W), .MODE(EV_LATCH_LOW), .CLR_ON_READ(1'b0)) u_llmk (
    .core_clk(core_clk), .rst_n(rst_n), .sig(lat_src),
    .rd_clr(1'b0), .wr_clr(wr_ok && aw_idx == `IDX_LLMK), .wr_mask(wdata_q & bmask),
    .q(llmk));
  event_cell #(.W(`DATA_W), .MODE(EV_EDGE_RISE), .CLR_ON_READ(1'b1)) u_ihsc (
    .core_clk(core_clk), .rst_n(rst_n), .sig(irq_src),
    .rd_clr(rd_fire && ar_idx == `IDX_IHSC), .wr_clr(1'b0), .wr_mask(bmask),
    .q(ihsc));
  event_cell #(.W(`DATA_W), .MODE(EV_EDGE_FALL), .CLR_ON_READ(1'b1)) u_ilsc (
    .core_clk(core_clk), .rst_n(rst_n), .sig(irq_src),
    .rd_clr(rd_fire && ar_idx == `IDX_ILSC), .wr_clr(1'b0), .wr_mask(bmask),
    .q(ilsc));
  event_cell #(.W(`DATA_W), .MODE(EV_EDGE_RISE), .CLR_ON_READ(1'b0)) u_ihmk (
    .core_clk(core_clk), .rst_n(rst_n), .sig(irq_src),
    .rd_clr(1'b0), .wr_clr(wr_ok && aw_idx == `IDX_IHMK), .wr_mask(wdata_q & bmask),
    .q(ihmk));
  event_cell #(.W(`DATA_W), .MODE(EV_EDGE_FALL), .CLR_ON_READ(1'b0)) u_ilmk (
    .core_clk(core_clk), .rst_n(rst_n), .sig(irq_src),
    .rd_clr(1'b0), .wr_clr(wr_ok && aw_idx == `IDX_ILMK), .wr_mask(wdata_q & bmask),
    .q(ilmk));

  // ==========================================================
  // software and hardware cells
  word_t stat, ien, next_ctrl, next_wo, next_rwh, next_stat, next_lor, next_sc;
  word_t next_strobe, next_ien, pending;
  logic lor_done, next_lor_done, next_event_req;

  assign pending = ihsc | ilsc | ihmk | ilmk;

  always_comb begin
    next_ctrl = ctrl_word;
    next_wo = wo_word;
    next_rwh = rwh_word;
    next_ien = ien;
    next_lor = lor_word;
    next_sc = sc_word & ~hw_done;
    next_strobe = `WORD_RST;
    next_stat = hw_status_in;
    next_lor_done = 1'b1;
    if (wr_ok) begin
      unique case (aw_idx)
        `IDX_CTRL: next_ctrl = (ctrl_word & ~bmask) | (wdata_q & bmask);
        `IDX_WO: next_wo = (wo_word & ~bmask) | (wdata_q & bmask);
        `IDX_RWH: next_rwh = (rwh_word & ~bmask) | (wdata_q & bmask);
        `IDX_IEN: next_ien = (ien & ~bmask) | (wdata_q & bmask);
        `IDX_LOR: next_lor = (lor_word & ~bmask) | (wdata_q & bmask);
        `IDX_SC: begin
          // a fresh command outranks a done from the previous one
          next_sc = (sc_word & ~bmask) | (wdata_q & bmask);
          next_strobe = wdata_q & bmask;
        end
        default: begin
          // read-only and read-clear cells drop the write, mask cells clear in their own instances
        end
      endcase
    end
    if (hw_load) begin
      next_rwh = hw_data;
    end
    if (!lor_done) begin
      next_lor = strap_in;
    end
    next_event_req = |(ien & pending);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_word <= `WORD_RST;
      wo_word <= `WORD_RST;
      rwh_word <= `WORD_RST;
      stat <= `WORD_RST;
      ien <= `WORD_RST;
      lor_word <= `WORD_RST;
      lor_done <= 1'b0;
      sc_word <= `WORD_RST;
      sc_strobe <= `WORD_RST;
      event_req <= 1'b0;
    end else begin
      ctrl_word <= next_ctrl;
      wo_word <= next_wo;
      rwh_word <= next_rwh;
      stat <= next_stat;
      ien <= next_ien;
      lor_word <= next_lor;
      lor_done <= next_lor_done;
      sc_word <= next_sc;
      sc_strobe <= next_strobe;
      event_req <= next_event_req;
    end
  end

  // ==========================================================
  // read multiplexer, write-only word reads back zero
  always_comb begin
    rd_err = !(ar_idx < `REG_COUNT);
    case (ar_idx)
      `IDX_CTRL: rd_word = ctrl_word;
      `IDX_STAT: rd_word = stat;
      `IDX_RWH: rd_word = rwh_word;
      `IDX_VIRT: rd_word = direct_mux_read;
      `IDX_LHSC: rd_word = lhsc;
      `IDX_LLSC: rd_word = llsc;
      `IDX_LHMK: rd_word = lhmk;
      `IDX_LLMK: rd_word = llmk;
      `IDX_IHSC: rd_word = ihsc;
      `IDX_ILSC: rd_word = ilsc;
      `IDX_IHMK: rd_word = ihmk;
      `IDX_ILMK: rd_word = ilmk;
      `IDX_IEN: rd_word = ien;
      `IDX_LOR: rd_word = lor_word;
      `IDX_SC: rd_word = sc_word;
      default: rd_word = `WORD_RST;
    endcase
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence sc_write;
    wr_ok && aw_idx == `IDX_SC && bmask == 16'hffff;
  endsequence
  sequence ctrl_write;
    wr_ok && aw_idx == `IDX_CTRL && bmask == 16'hffff;
  endsequence
  sequence virt_read;
    rd_fire && ar_idx == `IDX_VIRT;
  endsequence

  ctrl_write_a: assert property (ctrl_write |=> ctrl_word == $past(wdata_q))
    else $error("control word not updated by write");
  stat_delay_a: assert property (##1 1'b1 |-> stat == $past(hw_status_in))
    else $error("read-only cell not one cycle behind input");
  stat_read_a: assert property (rd_fire && ar_idx == `IDX_STAT |=>
    rdata[15:0] == $past(stat))
    else $error("read cell returned wrong value");
  wo_write_a: assert property (wr_ok && aw_idx == `IDX_WO && bmask == 16'hffff |=>
    wo_word == $past(wdata_q))
    else $error("write cell did not take value");
  rwh_prio_a: assert property (hw_load |=> rwh_word == $past(hw_data))
    else $error("hardware load lost");
  virt_live_a: assert property (virt_read |=> rvalid && rdata[15:0] == $past(direct_mux_read))
    else $error("virtual read not live");
  strobe_pulse_a: assert property (sc_write ##0 (wdata_q != '0) |=>
    sc_strobe == $past(wdata_q) ##1 sc_strobe == '0)
    else $error("strobe not one cycle wide");
  sc_hold_a: assert property (!wr_ok |=>
    (sc_word & ($past(sc_word) & ~$past(hw_done))) == ($past(sc_word) & ~$past(hw_done)))
    else $error("self-clearing bit dropped before done");
  lor_cap_a: assert property ($rose(lor_done) |-> lor_word == $past(strap_in))
    else $error("strap not captured after reset");
  ien_gate_a: assert property (##1 1'b1 |-> event_req == |($past(ien) & $past(pending)))
    else $error("interrupt request not gated by enable");
  map_err_a: assert property (do_wr && !(aw_idx < `REG_COUNT) |=>
    bvalid && bresp == `RESP_SLVERR)
    else $error("unmapped write not refused");
endmodule

// ### sim/register_access_type_cells_test.sv
// self-checking bench for the register access cell bank
`timescale 1ns/1ps
`include "cell_params.svh"

`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_errors++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end

module register_access_type_cells_test;
  import cell_pkg::*;
  // ==========================================================
  // clock, reset and bus
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, event_req;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  // ==========================================================
  // hardware side
  word_t hw_status_in = 16'h0000;
  word_t hw_data = 16'h0000;
  logic hw_load = 1'b0;
  word_t direct_mux_read = 16'h0000;
  word_t lat_src = 16'h0000;
  word_t irq_src = 16'h0000;
  word_t strap_in = 16'h0000;
  word_t hw_done = 16'h0000;
  word_t ctrl_word, wo_word, rwh_word, lor_word, sc_word, sc_strobe, strobe_val;
  // ==========================================================
  // bookkeeping
  int n_errors = 0;
  int samples_checked = 0;
  int strobe_cnt = 0;
  logic [31:0] seed = 32'h4881_3f5a;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [33:0] r_exp;
  logic [1:0] b_exp;

  always #10 core_clk = ~core_clk;

  reg_cells #(.ADDR_W(8)) dut (
    .core_clk(core_clk), .rst_n(rst_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .hw_status_in(hw_status_in), .hw_data(hw_data), .hw_load(hw_load),
    .direct_mux_read(direct_mux_read), .lat_src(lat_src), .irq_src(irq_src),
    .strap_in(strap_in), .hw_done(hw_done),
    .ctrl_word(ctrl_word), .wo_word(wo_word), .rwh_word(rwh_word),
    .lor_word(lor_word), .sc_word(sc_word), .sc_strobe(sc_strobe),
    .event_req(event_req)
  );

  function automatic word_t rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction

  function automatic logic [7:0] ad(input logic [5:0] idx);
    return {idx, 2'b00};
  endfunction

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic hang();
    n_errors++;
    $display("[ERR] handshake expected answer seen none");
    give_verdict();
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic fin(input string nm);
    $display("test %s done", nm);
  endtask

  // ==========================================================
  // bus master, expectations go to the queues
  task automatic wr(input logic [7:0] a, input word_t d, input logic [1:0] st,
                    input logic [1:0] resp);
    int i;
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= {2'b00, st};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bq.push_back(resp);
    for (i = 0; i < 64; i++) begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      // load dropped once the write has landed, so a software win would show
      if (!awvalid && !wvalid) hw_load <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        break;
      end
    end
    if (i == 64) hang();
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input word_t d, input logic [1:0] resp);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rq.push_back({resp, 16'h0000, d});
    for (i = 0; i < 64; i++) begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        break;
      end
    end
    if (i == 64) hang();
    @(posedge core_clk);
  endtask

  task automatic pulse_lat(input word_t a, input word_t b);
    lat_src <= a;
    @(posedge core_clk);
    lat_src <= b;
    tick(2);
  endtask

  // ==========================================================
  // monitors, oldest note against each answer
  always @(posedge core_clk) begin
    if (rvalid && rready) begin
      r_exp = (rq.size() > 0) ? rq.pop_front() : 34'h3_ffff_ffff;
      `CHK("rdata", r_exp[31:0], rdata)
      `CHK("rresp", r_exp[33:32], rresp)
    end
    if (bvalid && bready) begin
      b_exp = (bq.size() > 0) ? bq.pop_front() : 2'h3;
      `CHK("bresp", b_exp, bresp)
    end
    if (sc_strobe !== 16'h0000) begin
      strobe_cnt++;
      strobe_val = sc_strobe;
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    word_t v, w, p, m, s;
    s = rnd();
    strap_in <= s;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    tick(2);
    strap_in <= ~s;
    tick(2);
    `CHK("lor_word", s, lor_word)
    fin("reset capture");
    v = rnd();
    w = rnd();
    wr(ad(`IDX_CTRL), v, 2'b11, `RESP_OKAY);
    `CHK("ctrl_word", v, ctrl_word)
    wr(ad(`IDX_CTRL), w, 2'b01, `RESP_OKAY);
    rd(ad(`IDX_CTRL), {v[15:8], w[7:0]}, `RESP_OKAY);
    hw_status_in <= v;
    tick(2);
    rd(ad(`IDX_STAT), v, `RESP_OKAY);
    wr(ad(`IDX_STAT), ~v, 2'b11, `RESP_OKAY);
    rd(ad(`IDX_STAT), v, `RESP_OKAY);
    wr(ad(`IDX_WO), w, 2'b11, `RESP_OKAY);
    `CHK("wo_word", w, wo_word)
    rd(ad(`IDX_WO), 16'h0000, `RESP_OKAY);
    fin("plain cells");
    wr(ad(`IDX_RWH), v, 2'b11, `RESP_OKAY);
    rd(ad(`IDX_RWH), v, `RESP_OKAY);
    hw_data <= w;
    hw_load <= 1'b1;
    wr(ad(`IDX_RWH), ~w, 2'b11, `RESP_OKAY);
    `CHK("rwh_word", w, rwh_word)
    direct_mux_read <= ~v;
    tick(1);
    rd(ad(`IDX_VIRT), ~v, `RESP_OKAY);
    fin("hardware cells");
    p = rnd() | 16'h0001;
    m = rnd();
    rd(ad(`IDX_LHSC), 16'h0000, `RESP_OKAY);
    pulse_lat(p, 16'h0000);
    rd(ad(`IDX_LHSC), p, `RESP_OKAY);
    rd(ad(`IDX_LHSC), 16'h0000, `RESP_OKAY);
    // level held through the clearing read, the new set must survive
    lat_src <= p;
    tick(2);
    rd(ad(`IDX_LHSC), p, `RESP_OKAY);
    rd(ad(`IDX_LHSC), p, `RESP_OKAY);
    lat_src <= 16'hffff;
    tick(2);
    rd(ad(`IDX_LLSC), 16'hffff, `RESP_OKAY);
    rd(ad(`IDX_LLSC), 16'h0000, `RESP_OKAY);
    pulse_lat(~p, 16'hffff);
    rd(ad(`IDX_LLSC), p, `RESP_OKAY);
    lat_src <= 16'h0000;
    tick(2);
    rd(ad(`IDX_LHMK), 16'hffff, `RESP_OKAY);
    wr(ad(`IDX_LHMK), m, 2'b11, `RESP_OKAY);
    rd(ad(`IDX_LHMK), ~m, `RESP_OKAY);
    lat_src <= 16'hffff;
    tick(2);
    wr(ad(`IDX_LLMK), m, 2'b11, `RESP_OKAY);
    rd(ad(`IDX_LLMK), ~m, `RESP_OKAY);
    wr(ad(`IDX_LLMK), 16'hffff, 2'b10, `RESP_OKAY);
    rd(ad(`IDX_LLMK), ~m & 16'h00ff, `RESP_OKAY);
    fin("latch cells");
    irq_src <= p;
    tick(2);
    rd(ad(`IDX_IHSC), p, `RESP_OKAY);
    rd(ad(`IDX_IHSC), 16'h0000, `RESP_OKAY);
    rd(ad(`IDX_IHMK), p, `RESP_OKAY);
    rd(ad(`IDX_IHMK), p, `RESP_OKAY);
    wr(ad(`IDX_IHMK), p, 2'b11, `RESP_OKAY);
    rd(ad(`IDX_IHMK), 16'h0000, `RESP_OKAY);
    irq_src <= 16'h0000;
    tick(2);
    rd(ad(`IDX_ILSC), p, `RESP_OKAY);
    rd(ad(`IDX_ILSC), 16'h0000, `RESP_OKAY);
    wr(ad(`IDX_IEN), ~p, 2'b11, `RESP_OKAY);
    tick(1);
    `CHK("event_req", 1'b0, event_req)
    wr(ad(`IDX_IEN), p, 2'b11, `RESP_OKAY);
    tick(1);
    `CHK("event_req", 1'b1, event_req)
    rd(ad(`IDX_IEN), p, `RESP_OKAY);
    rd(ad(`IDX_ILMK), p, `RESP_OKAY);
    wr(ad(`IDX_ILMK), 16'hffff, 2'b11, `RESP_OKAY);
    rd(ad(`IDX_ILMK), 16'h0000, `RESP_OKAY);
    tick(1);
    `CHK("event_req", 1'b0, event_req)
    fin("edge cells");
    // strobe width counted by the monitor, one cycle expected
    strobe_cnt = 0;
    wr(ad(`IDX_SC), p, 2'b11, `RESP_OKAY);
    `CHK("strobe cycles", 1, strobe_cnt)
    `CHK("sc_strobe", p, strobe_val)
    `CHK("sc_word", p, sc_word)
    hw_done <= p & 16'h00ff;
    tick(2);
    hw_done <= 16'h0000;
    `CHK("sc_word", p & 16'hff00, sc_word)
    rd(ad(`IDX_SC), p & 16'hff00, `RESP_OKAY);
    fin("self clearing");
    rd(8'h80, 16'h0000, `RESP_SLVERR);
    wr(8'h80, v, 2'b11, `RESP_SLVERR);
    wr(8'h7c, v, 2'b11, `RESP_OKAY);
    rd(8'h7c, 16'h0000, `RESP_OKAY);
    rd(8'h40, 16'h0000, `RESP_OKAY);
    wr(ad(`IDX_LOR), w, 2'b11, `RESP_OKAY);
    `CHK("lor_word", w, lor_word)
    rd(ad(`IDX_LOR), w, `RESP_OKAY);
    fin("address map");
    tick(2);
    `CHK("pending answers", 0, rq.size() + bq.size())
    give_verdict();
  end
endmodule
